// ===== ssc_map.svh
// register offsets, field positions and timing counts of the step sequencer
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_CLK_MHZ       25
`define SSC_TICK_NS       100000
`define SSC_TICK_CYC      ((`SSC_TICK_NS * `SSC_CLK_MHZ) / 1000)
`define SSC_OFF_CTRL      8'h00
`define SSC_OFF_STATUS    8'h04
`define SSC_OFF_SEQ_CFG   8'h08
`define SSC_OFF_PROG_SEL  8'h0c
`define SSC_OFF_PROG_TIME 8'h10
`define SSC_OFF_PROG_CTRL 8'h14
`define SSC_OFF_PROG_WAVE 8'h18
`define SSC_CMD_START     0
`define SSC_CMD_HOLD      1
`define SSC_CMD_STOP      2
`define SSC_CMD_BRANCH    3
`define SSC_PC_JUMP_LSB   0
`define SSC_PC_BR_LSB     8
`define SSC_PC_CNT_LSB    16
`define SSC_PC_TERM_LSB   26
`define SSC_PC_PHASE_BIT  28
`define SSC_PC_SYNC_LSB   29
`define SSC_SEQ_FIXED_BIT 8
`define SSC_TIME_W        24
`define SSC_CNT_W         10
`define SSC_LAST_RST      8'h01
`endif

// ===== ssc_pkg.sv
// types shared by the step sequencer files
`default_nettype none
package ssc_pkg;
  typedef enum logic [1:0] {SSC_IDLE, SSC_RUN, SSC_HOLD} ssc_state_t;
  typedef enum logic [1:0] {
    SSC_CONTINUE_SEQUENCE,
    SSC_TERM_HOLD,
    SSC_TERM_STOP
  } ssc_term_t;
endpackage
`default_nettype wire

// ===== ssc_tick.sv
// fixed step-time tick divided down from the system clock
`timescale 1ns/1ps
`default_nettype none
module ssc_tick #(
  parameter int DIV = 2500
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [$clog2(DIV)-1:0] cnt;

  initial begin
    if (DIV < 2) $error("ssc_tick: DIV must be at least 2");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt == ($clog2(DIV))'(DIV - 1)) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== ssc_timer.sv
// loadable step timer that pauses whenever run is low
`timescale 1ns/1ps
`default_nettype none
module ssc_timer #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  input  wire logic         tick,
  output logic              done
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      done <= 1'b0;
    end else if (load) begin
      // a zero time would never end; treat it as the shortest step
      cnt  <= (load_val == '0) ? W'(1) : load_val;
      done <= 1'b0;
    end else if (run && tick && !done) begin
      cnt <= cnt - 1'b1;
      if (cnt == W'(1)) begin
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== ssc_core.sv
// step sequencer core with apb register access and step program memory
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
// Summary of operation
// - start in idle enters run and begins step one at once.
// - start after a hold command resumes the paused step where it stopped.
// - start after a termination hold goes to that step's jump target.
// - hold command pauses step timing and freezes the output.
// - stop goes idle at once; regular output keeps values at stop.
// - branch goes to the current step's branch target from present output.
// - loops are made only with each step's jump target and count.
// - every step owns its own jump counter so loops can nest.
// - looped block runs one more time than its jump count.
// - a running step drives its sync code onto the sync outputs.
// - in regular output the sync outputs are false.
// - end-phase steps last their time plus wait for zero phase.
// - during the phase wait the output holds the step's final values.
// - waveform changes between steps only through sixteen stored slots.
// - with sine or square the waveform stays fixed for the sequence.
// - termination selects continue, hold or idle and beats the jump.
// - jump target zero means next step; 1 to 255 names a step.
// - jump count 1 to 999 is finite; zero jumps forever.
// - a step ends when its time, 0.1 ms to 999.9999 s, expires.
module ssc_core #(
  parameter int TICK_CYC = `SSC_TICK_CYC,
  parameter int STEPS    = 256
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        phase_zero,
  output logic      [1:0]  sync_out,
  output logic      [3:0]  wave_slot,
  output logic             out_freeze,
  output logic             stop_capture,
  output logic             seq_active
);
  initial begin
    if (STEPS != 256) $error("ssc_core: STEPS must be 256");
    if (TICK_CYC < 2) $error("ssc_core: TICK_CYC must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // step program memory
  logic [`SSC_TIME_W-1:0] time_mem [STEPS];
  logic [31:0]            ctrl_mem [STEPS];
  logic [3:0]             wave_mem [STEPS];
  logic [`SSC_CNT_W-1:0]  jump_ctr [STEPS];
  logic [7:0]             prog_sel;
  logic [7:0]             last_step;
  logic                   wave_fixed;

  ssc_pkg::ssc_state_t    state;
  logic [7:0]             cur;
  logic                   held_by_term;
  logic                   phase_wait;
  logic                   load_timer;
  logic                   tick;
  logic                   timer_done;

  logic                   wr_en;
  logic                   rd_en;
  logic [3:0]             cmd;
  logic [31:0]            cur_ctrl;
  logic [7:0]             cur_jump;
  logic [7:0]             cur_branch;
  logic [`SSC_CNT_W-1:0]  cur_count;
  ssc_pkg::ssc_term_t     cur_term;
  logic                   step_end;
  logic [7:0]             next_step;
  logic                   next_idle;
  logic                   next_take_jump;
  logic                   end_taken;

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && !penable;
  assign cmd   = (wr_en && paddr == `SSC_OFF_CTRL) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge clk) begin
    if (wr_en && paddr == `SSC_OFF_PROG_TIME) begin
      time_mem[prog_sel] <= pwdata[`SSC_TIME_W-1:0];
    end
    if (wr_en && paddr == `SSC_OFF_PROG_CTRL) begin
      ctrl_mem[prog_sel] <= pwdata;
    end
    if (wr_en && paddr == `SSC_OFF_PROG_WAVE) begin
      wave_mem[prog_sel] <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_sel   <= 8'h01;
      last_step  <= `SSC_LAST_RST;
      wave_fixed <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `SSC_OFF_PROG_SEL) begin
        prog_sel <= pwdata[7:0];
      end else if (paddr == `SSC_OFF_SEQ_CFG && state == ssc_pkg::SSC_IDLE)
      begin
        // waveform mode only changes outside a sequence
        last_step  <= pwdata[7:0];
        wave_fixed <= pwdata[`SSC_SEQ_FIXED_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: no wait state, answer registered in the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_en;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      // writes to unknown offsets are dropped quietly, only reads err
      if (rd_en && !pwrite) begin
        if (paddr == `SSC_OFF_CTRL) begin
          prdata <= 32'h0000_0000;
        end else if (paddr == `SSC_OFF_STATUS) begin
          prdata <= {16'h0000, cur, 4'h0, phase_wait, held_by_term,
                     state};
        end else if (paddr == `SSC_OFF_SEQ_CFG) begin
          prdata <= {23'h000000, wave_fixed, last_step};
        end else if (paddr == `SSC_OFF_PROG_SEL) begin
          prdata <= {24'h000000, prog_sel};
        end else if (paddr == `SSC_OFF_PROG_TIME) begin
          prdata <= {8'h00, time_mem[prog_sel]};
        end else if (paddr == `SSC_OFF_PROG_CTRL) begin
          prdata <= ctrl_mem[prog_sel];
        end else if (paddr == `SSC_OFF_PROG_WAVE) begin
          prdata <= {28'h0000000, wave_mem[prog_sel]};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // step timing
  // fixed tick
  ssc_tick #(.DIV(TICK_CYC)) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  ssc_timer #(.W(`SSC_TIME_W)) u_timer (
    .clk      (clk),
    .rst      (rst),
    .load     (load_timer),
    .load_val (time_mem[cur]),
    .run      (state == ssc_pkg::SSC_RUN),
    .tick     (tick),
    .done     (timer_done)
  );

  assign cur_ctrl   = ctrl_mem[cur];
  assign cur_jump   = cur_ctrl[`SSC_PC_JUMP_LSB +: 8];
  assign cur_branch = cur_ctrl[`SSC_PC_BR_LSB +: 8];
  assign cur_count  = cur_ctrl[`SSC_PC_CNT_LSB +: `SSC_CNT_W];
  assign cur_term   = ssc_pkg::ssc_term_t'(cur_ctrl[`SSC_PC_TERM_LSB +: 2]);

  // end at expiry, or at the next zero phase when enabled
  assign step_end = state == ssc_pkg::SSC_RUN && !load_timer && timer_done
                    && (!cur_ctrl[`SSC_PC_PHASE_BIT] || phase_zero);

  // a step end the state machine really takes, so the counters follow it
  assign end_taken = step_end && !cmd[`SSC_CMD_STOP] && !cmd[`SSC_CMD_HOLD]
                     && !(cmd[`SSC_CMD_BRANCH] && cur_branch != 8'h00);

  // jump target and count shape the flow; last step ends it
  always_comb begin
    next_take_jump = 1'b0;
    next_step      = cur + 8'h01;
    next_idle      = (cur == last_step) || (cur == 8'hff);
    // zero jump target means next step
    if (cur_jump != 8'h00) begin
      if (cur_count == '0 || jump_ctr[cur] < cur_count) begin
        next_take_jump = 1'b1;
        next_step      = cur_jump;
        next_idle      = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state        <= ssc_pkg::SSC_IDLE;
      cur          <= 8'h00;
      held_by_term <= 1'b0;
      load_timer   <= 1'b0;
      stop_capture <= 1'b0;
    end else begin
      load_timer   <= 1'b0;
      stop_capture <= 1'b0;
      if (cmd[`SSC_CMD_STOP]) begin
        // stop wins over every other command
        if (state != ssc_pkg::SSC_IDLE) begin
          stop_capture <= 1'b1;
        end
        state        <= ssc_pkg::SSC_IDLE;
        cur          <= 8'h00;
        held_by_term <= 1'b0;
      end else if (cmd[`SSC_CMD_HOLD] && state == ssc_pkg::SSC_RUN) begin
        state        <= ssc_pkg::SSC_HOLD;
        held_by_term <= 1'b0;
      end else if (cmd[`SSC_CMD_BRANCH] && state == ssc_pkg::SSC_RUN &&
                   cur_branch != 8'h00) begin
        cur        <= cur_branch;
        load_timer <= 1'b1;
      end else if (cmd[`SSC_CMD_START] && state != ssc_pkg::SSC_RUN) begin
        state        <= ssc_pkg::SSC_RUN;
        held_by_term <= 1'b0;
        if (state == ssc_pkg::SSC_IDLE) begin
          cur        <= 8'h01;
          load_timer <= 1'b1;
        end else if (held_by_term) begin
          cur        <= (cur_jump == 8'h00) ? cur + 8'h01 : cur_jump;
          load_timer <= 1'b1;
        end
        // after a hold command the timer simply resumes
      end else if (step_end) begin
        // termination setting beats the jump target
        if (cur_term == ssc_pkg::SSC_TERM_HOLD) begin
          state        <= ssc_pkg::SSC_HOLD;
          held_by_term <= 1'b1;
        end else if (cur_term == ssc_pkg::SSC_TERM_STOP || next_idle) begin
          state        <= ssc_pkg::SSC_IDLE;
          cur          <= 8'h00;
          stop_capture <= 1'b1;
        end else begin
          cur        <= next_step;
          load_timer <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STEPS; i++) begin
        jump_ctr[i] <= '0;
      end
    end else if (cmd[`SSC_CMD_START] && !cmd[`SSC_CMD_STOP] &&
                 state == ssc_pkg::SSC_IDLE) begin
      for (int i = 0; i < STEPS; i++) begin
        jump_ctr[i] <= '0;
      end
    end else if (end_taken && cur_term != ssc_pkg::SSC_TERM_HOLD &&
                 cur_term != ssc_pkg::SSC_TERM_STOP && cur_jump != 8'h00) begin
      // count jumps, so the block runs count plus one times
      if (next_take_jump) begin
        if (cur_count != '0) begin
          jump_ctr[cur] <= jump_ctr[cur] + 1'b1;
        end
      end else begin
        // reload so an outer loop can run this one again
        jump_ctr[cur] <= '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_wait <= 1'b0;
    end else begin
      phase_wait <= state == ssc_pkg::SSC_RUN && timer_done && !load_timer
                    && cur_ctrl[`SSC_PC_PHASE_BIT] && !step_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs toward the output stage and connector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_active <= 1'b0;
    end else begin
      seq_active <= state != ssc_pkg::SSC_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_freeze <= 1'b0;
    end else begin
      // freeze during hold and during the phase wait
      out_freeze <= state == ssc_pkg::SSC_HOLD || phase_wait;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_out <= 2'h0;
    end else if (state != ssc_pkg::SSC_IDLE) begin
      // step sync code while a step is in force
      sync_out <= cur_ctrl[`SSC_PC_SYNC_LSB +: 2];
    end else begin
      sync_out <= 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wave_slot <= 4'h0;
    end else if (state != ssc_pkg::SSC_IDLE && !wave_fixed) begin
      // slot per step only in arbitrary mode
      wave_slot <= wave_mem[cur];
    end else if (state == ssc_pkg::SSC_IDLE) begin
      // outside a sequence the slot is cleared; a fixed waveform keeps it untouched
      wave_slot <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ===== ssc_core_sva.sv
// assertion checker for the step sequencer core ports
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
module ssc_core_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        phase_zero,
  input wire logic [1:0]  sync_out,
  input wire logic [3:0]  wave_slot,
  input wire logic        out_freeze,
  input wire logic        stop_capture,
  input wire logic        seq_active
);
  logic wr_ctrl;
  // control write at its access edge
  assign wr_ctrl = psel && penable && pready && pwrite
                   && paddr == `SSC_OFF_CTRL;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////
  sync_idle_a: assert property (!seq_active |-> sync_out == 2'h0)
    else $error("sync code outside a sequence");
  wave_idle_a: assert property (!seq_active |-> wave_slot == 4'h0)
    else $error("wave slot outside a sequence");
  start_run_a: assert property (wr_ctrl && pwdata[3:0] == 4'h1
    && !seq_active |-> ##[1:3] seq_active) else $error("start ignored");
  hold_freeze_a: assert property (wr_ctrl && pwdata[3:0] == 4'h2
    && seq_active && !stop_capture |-> ##[1:3] out_freeze)
    else $error("hold not frozen");
  stop_cmd_a: assert property (wr_ctrl && pwdata[2] && seq_active
    && !stop_capture |-> ##[1:3] stop_capture)
    else $error("stop gave no capture");
  stop_pulse_a: assert property (stop_capture |=> !stop_capture)
    else $error("capture longer than one cycle");
  stop_idle_a: assert property (stop_capture |-> ##[0:2] !seq_active)
    else $error("still active after capture");
  ready_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data without ready");
  slverr_read_a: assert property (pslverr |-> pready && !pwrite)
    else $error("error outside a read answer");
endmodule
bind ssc_core ssc_core_sva u_ssc_core_sva (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phase_zero(phase_zero), .sync_out(sync_out), .wave_slot(wave_slot),
  .out_freeze(out_freeze), .stop_capture(stop_capture),
  .seq_active(seq_active));
`default_nettype wire

// ===== ssc_phase_src.sv
// ac phase source pulsing at each zero crossing while enabled
`timescale 1ns/1ps
`default_nettype none
module ssc_phase_src #(
  parameter int PERIOD = 30
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  output logic      phase_zero
);
  int cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt        <= 0;
      phase_zero <= 1'b0;
    end else begin
      cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      phase_zero <= en && cnt == PERIOD - 1;
    end
  end
endmodule
`default_nettype wire

// ===== step_sequence_controller_bench.sv
// self-checking bench for the step sequencer core
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
module step_sequence_controller_bench;
  logic        clk, rst, psel, penable, pwrite, phase_en, pready, pslverr;
  logic        phase_zero, out_freeze, stop_capture, seq_active;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  sync_out, last_sync;
  logic [3:0]  wave_slot, wv;
  logic [32:0] exp_q[$];
  int          num_errors, n_checks, cycles, n2, ns, k, seed;
  always #20 clk = ~clk;
  ssc_core #(.TICK_CYC(4), .STEPS(256)) u_ssc_core (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_zero(phase_zero), .sync_out(sync_out), .wave_slot(wave_slot),
    .out_freeze(out_freeze), .stop_capture(stop_capture),
    .seq_active(seq_active));
  ssc_phase_src #(.PERIOD(30)) u_ssc_phase_src (.clk(clk), .rst(rst),
    .en(phase_en), .phase_zero(phase_zero));
  //////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: pin %h not %h", $time, g, x);
    end
  endtask
  task automatic cmp_rd(input logic [32:0] g, input logic [32:0] x);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: read %h not %h", $time, g, x);
    end
  endtask
  // request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic err);
    exp_q.push_back({err, x});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [3:0] b);
    apb(1'b1, `SSC_OFF_CTRL, {28'h0, b});
  endtask
  task automatic prog(input logic [7:0] s, input logic [23:0] t,
                      input logic [31:0] c, input logic [3:0] w);
    apb(1'b1, `SSC_OFF_PROG_SEL, {24'h0, s});
    apb(1'b1, `SSC_OFF_PROG_TIME, {8'h0, t});
    apb(1'b1, `SSC_OFF_PROG_CTRL, c);
    apb(1'b1, `SSC_OFF_PROG_WAVE, {28'h0, w});
  endtask
  //////////////////////////////////////////////////////////////////////
  // read answers checked against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      cmp_rd({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // counts step two entries, captures and the hang limit
  always @(posedge clk) begin
    last_sync <= sync_out;
    if (sync_out === 2'h2 && last_sync !== 2'h2) n2++;
    if (stop_capture === 1'b1) ns++;
    cycles++;
    if (cycles > 30000) begin
      num_errors++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    seed = 57844;
    {clk, rst, psel, penable, pwrite, phase_en} = 6'h10;
    {paddr, pwdata, last_sync} = 42'h0;
    {num_errors, n_checks, cycles, n2, ns} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({30'h0, sync_out}, 32'h0);
    rd(`SSC_OFF_STATUS, 32'h0, 1'b0);
    rd(`SSC_OFF_SEQ_CFG, 32'h1, 1'b0);
    rd(8'h1c, 32'h0, 1'b1);
    // unmapped write must pass without an error answer
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    wv = 4'($random(seed));
    prog(8'h01, 24'h2, 32'h2000_0000, wv);
    prog(8'h02, 24'h2, 32'h4002_0001, 4'h0);
    prog(8'h03, 24'h2, 32'h7800_0000, 4'h0);
    apb(1'b1, `SSC_OFF_SEQ_CFG, 32'h3);
    // a second run from idle must loop the same number of times
    for (int p = 0; p < 2; p++) begin
      n2 = 0;
      cmd(4'h1);
      while (sync_out !== 2'h1) @(posedge clk);
      chk({28'h0, wave_slot}, {28'h0, wv});
      while (sync_out !== 2'h3) @(posedge clk);
      repeat (20) @(posedge clk);
      chk({31'h0, out_freeze}, 32'h1);
      rd(`SSC_OFF_STATUS, 32'h0309, 1'b0);
      k = ns;
      phase_en <= 1'b1;
      while (ns == k) @(posedge clk);
      phase_en <= 1'b0;
      chk(n2, 3);
      repeat (2) @(posedge clk);
      chk({30'h0, sync_out}, 32'h0);
    end
    prog(8'h01, 24'd40, 32'h2000_0400, 4'h1);
    prog(8'h04, 24'h1, 32'h0400_0005, 4'h2);
    prog(8'h05, 24'd100, 32'h6800_0000, 4'h3);
    cmd(4'h1);
    repeat (10) @(posedge clk);
    cmd(4'h2);
    rd(`SSC_OFF_STATUS, 32'h0102, 1'b0);
    chk({31'h0, out_freeze}, 32'h1);
    chk({31'h0, seq_active}, 32'h1);
    cmd(4'h1);
    rd(`SSC_OFF_STATUS, 32'h0101, 1'b0);
    cmd(4'h8);
    repeat (20) @(posedge clk);
    rd(`SSC_OFF_STATUS, 32'h0406, 1'b0);
    cmd(4'h1);
    rd(`SSC_OFF_STATUS, 32'h0501, 1'b0);
    chk({30'h0, sync_out}, 32'h3);
    k = ns;
    cmd(4'h4);
    repeat (3) @(posedge clk);
    chk(ns - k, 1);
    rd(`SSC_OFF_STATUS, 32'h0, 1'b0);
    chk({31'h0, seq_active}, 32'h0);
    // nested loops: the inner count must come back for the outer pass
    prog(8'h01, 24'h1, 32'h2000_0000, 4'h5);
    prog(8'h02, 24'h1, 32'h4001_0001, 4'h6);
    prog(8'h03, 24'h1, 32'h6001_0001, 4'h7);
    apb(1'b1, `SSC_OFF_SEQ_CFG, 32'h103);
    n2 = 0;
    k = ns;
    cmd(4'h1);
    apb(1'b1, `SSC_OFF_SEQ_CFG, 32'h0ff);
    rd(`SSC_OFF_SEQ_CFG, 32'h103, 1'b0);
    chk({28'h0, wave_slot}, 32'h0);
    chk({31'h0, seq_active}, 32'h1);
    while (ns == k) @(posedge clk);
    chk(n2, 4);
    // zero count jumps for ever
    prog(8'h01, 24'h1, 32'h2000_0001, 4'h0);
    cmd(4'h1);
    repeat (100) @(posedge clk);
    rd(`SSC_OFF_STATUS, 32'h0101, 1'b0);
    cmd(4'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, seq_active}, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
